// [pkg/serial_shift_pkg.sv]
// constants shared by the universal serial shift unit
// assumes a 25 MHz system clock sampling all pins through synchronisers
package serial_shift_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // start detector delay on the data line, least figure
    localparam int START_DELAY_NS = 50;
    localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] WM_OFF = 2'h0;
    localparam logic [1:0] WM_THREE = 2'h1;
    localparam logic [1:0] WM_TWO = 2'h2;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [3:0] COUNT_MAX = 4'hF;
    localparam logic [2:0] SYNC_RESET = 3'h7;
endpackage : serial_shift_pkg

// [logic/universal_serial_shift_unit.sv]
// universal serial shift unit: shift register, edge counter, start detector
// assumes software control bits arrive as plain ports on clk_sys; pins are async
//
// What this block does
// - edge select zero: sample rise, shift fall
// - edge select one: sample fall, shift rise
// - one bit shifted per serial clock cycle
// - counter counts both edges, overflow sets flag
// - overflow flag can wake processor from idle
// - toggle plus strobe gives half-rate clock
// - two-wire has no slew or filtering
// - data fall with clock high sets start
// - data low when shift msb or port zero
// - start holds clock low after falling edge
// - two-wire slave samples on rising clock
// - hold mode: overflow after eight bits holds clock low
// - unaddressed slave releases clock, awaits start
// - data line delayed before start sampling
// - start condition detection only in two-wire mode
// - three-wire external clock edges set start flag
// - hold mode overflow holds clock until cleared
// - external source: strobe selects counter clock
// - toggle strobe inverts clock port, reads zero
`timescale 1ns/1ps
module universal_serial_shift_unit
    import serial_shift_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [1:0] wireModeSelect,
    input wire logic externalClockSelect,
    input wire logic clockEdgeSelect,
    input wire logic softwareShiftStrobe,
    input wire logic clockToggleStrobe,
    input wire logic shiftWrite,
    input wire logic [WIDTH-1:0] shiftWriteData,
    input wire logic countWrite,
    input wire logic [3:0] countWriteData,
    input wire logic overflowClear,
    input wire logic startClear,
    input wire logic dataLinePortOutput,
    input wire logic dataLineDirectionBit,
    input wire logic clockPortWrite,
    input wire logic clockPortWriteData,
    input wire logic clockLineDirectionBit,
    input wire logic dataLineIn,
    input wire logic clockLineIn,
    output logic [WIDTH-1:0] serialShiftData,
    output logic [3:0] counterValue,
    output logic counterOverflowFlag,
    output logic startDetectFlag,
    output logic wakeRequest,
    output logic clockLinePortOutput,
    output logic dataLineOut,
    output logic dataLineOe_n,
    output logic clockLineOut,
    output logic clockLineOe_n
);
    logic [2:0] dataSync_r;
    logic [2:0] clkSync_r;
    logic dataLvl_r;
    logic clkLvl_r;
    logic [START_DELAY_CYC:0] dataDly_r;
    logic [WIDTH-1:0] shift_r;
    logic [WIDTH-1:0] shift_nxt;
    logic outLatch_r;
    logic [3:0] count_r;
    logic ovf_r;
    logic start_r;
    logic startHold_r;
    logic clkPort_r;
    logic sampledBit_r;

    // edge detection helper used for both pin lines
    function automatic logic stable_change(input logic [2:0] s, input logic lvl);
        return (s[1] == s[2]) && (s[2] != lvl);
    endfunction : stable_change

    // three-stage synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dataSync_r <= SYNC_RESET;
            clkSync_r <= SYNC_RESET;
            dataLvl_r <= 1'b1;
            clkLvl_r <= 1'b1;
        end
        else
        begin
            dataSync_r <= {dataSync_r[1:0], dataLineIn};
            clkSync_r <= {clkSync_r[1:0], clockLineIn};
            if (stable_change(dataSync_r, dataLvl_r))
                dataLvl_r <= dataSync_r[2];
            if (stable_change(clkSync_r, clkLvl_r))
                clkLvl_r <= clkSync_r[2];
        end
    end

    wire clkRise = stable_change(clkSync_r, clkLvl_r) && clkSync_r[2];
    wire clkFall = stable_change(clkSync_r, clkLvl_r) && !clkSync_r[2];
    wire clkEdge = clkRise || clkFall;
    wire extSrc = externalClockSelect;
    wire twoWire = wireModeSelect[1];
    // sampling edge per edge select; shift edge is the opposite one
    wire sampleEdge = extSrc && (clockEdgeSelect ? clkFall : clkRise);
    wire shiftEdge = extSrc && (clockEdgeSelect ? clkRise : clkFall);
    wire swShift = !extSrc && !clockEdgeSelect && softwareShiftStrobe;
    // counter clock: external both edges, toggle strobe, or software strobe
    wire countTick = extSrc ? (softwareShiftStrobe ? clockToggleStrobe : clkEdge)
                            : swShift;

    // delayed data line view for the start detector
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            dataDly_r <= '1;
        else
            dataDly_r <= {dataDly_r[START_DELAY_CYC-1:0], dataLvl_r};
    end

    wire dataFallDly = dataDly_r[START_DELAY_CYC] && !dataDly_r[START_DELAY_CYC-1];
    wire startCond = twoWire && dataFallDly && clkLvl_r;
    wire edgeStart = !twoWire && extSrc && !softwareShiftStrobe && clkEdge;

    // next shift register contents; bit entering is the one sampled earlier, or the live data level for software shifts
    always_comb
    begin
        shift_nxt = shift_r;
        if (shiftWrite)
            shift_nxt = shiftWriteData;
        else if (shiftEdge || swShift)
            shift_nxt = {shift_r[WIDTH-2:0], swShift ? dataLvl_r : sampledBit_r};
    end

    // shift register, sampled input bit and output latch
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_r <= SHIFT_RESET;
            sampledBit_r <= 1'b0;
            outLatch_r <= 1'b0;
        end
        else
        begin
            shift_r <= shift_nxt;
            if (sampleEdge)
                sampledBit_r <= dataLvl_r;
            // latch transparent for software clocking, else updates on shift edge
            if (!extSrc || shiftEdge || shiftWrite)
                outLatch_r <= shift_nxt[WIDTH-1];
        end
    end

    // 4-bit edge counter with preset and wrap
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            count_r <= COUNT_RESET;
        else if (countWrite)
            count_r <= countWriteData;
        else if (countTick)
            count_r <= count_r + 4'h1;
    end

    wire overflowEvt = countTick && !countWrite && (count_r == COUNT_MAX);

    // sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ovf_r <= 1'b0;
            start_r <= 1'b0;
        end
        else
        begin
            if (overflowEvt)
                ovf_r <= 1'b1;
            else if (overflowClear)
                ovf_r <= 1'b0;
            if (startCond || edgeStart)
                start_r <= 1'b1;
            else if (startClear)
                start_r <= 1'b0;
        end
    end

    // start detector clock hold: armed by falling clock after start
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            startHold_r <= 1'b0;
        else if (!twoWire || (startClear && !startCond))
            startHold_r <= 1'b0;
        else if (start_r && clkFall)
            startHold_r <= 1'b1;
    end

    // clock port bit: software write or toggle strobe inverts it
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            clkPort_r <= 1'b1;
        else if (clockPortWrite)
            clkPort_r <= clockPortWriteData;
        else if (clockToggleStrobe)
            clkPort_r <= !clkPort_r;
    end

    wire holdClk = startHold_r || (startCond && clkFall)
                 || (wireModeSelect == WM_TWO_HOLD && (ovf_r || overflowEvt));
    // pin drivers, registered; open drain in two-wire, push-pull in three-wire
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dataLineOut <= 1'b1;
            dataLineOe_n <= 1'b1;
            clockLineOut <= 1'b1;
            clockLineOe_n <= 1'b1;
        end
        else
        begin
            // no slew limiting or filtering beyond synchronisers in two-wire mode
            if (twoWire)
            begin
                dataLineOut <= 1'b0;
                dataLineOe_n <= !(dataLineDirectionBit
                                 && (!outLatch_r || !dataLinePortOutput));
                clockLineOut <= 1'b0;
                clockLineOe_n <= !(clockLineDirectionBit
                                  && (!clkPort_r || holdClk));
            end
            else
            begin
                dataLineOut <= outLatch_r;
                dataLineOe_n <= !(wireModeSelect == WM_THREE && dataLineDirectionBit);
                clockLineOut <= clkPort_r;
                clockLineOe_n <= !clockLineDirectionBit;
            end
        end
    end

    // status outputs straight from flops
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            serialShiftData <= SHIFT_RESET;
            counterValue <= COUNT_RESET;
            counterOverflowFlag <= 1'b0;
            startDetectFlag <= 1'b0;
            wakeRequest <= 1'b0;
            clockLinePortOutput <= 1'b1;
        end
        else
        begin
            serialShiftData <= shift_r;
            counterValue <= count_r;
            counterOverflowFlag <= ovf_r;
            startDetectFlag <= start_r;
            wakeRequest <= ovf_r || start_r;
            clockLinePortOutput <= clkPort_r;
        end
    end

    // checks
    a_overflow_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
        overflowEvt |=> ovf_r) else $error("overflow did not set flag");
    a_counter_wraps: assert property (@(posedge clk_sys) disable iff (sys_rst)
        overflowEvt |=> count_r == COUNT_RESET) else $error("counter did not wrap");
    a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        countTick && !countWrite |=> count_r == $past(count_r) + 4'h1)
        else $error("counter step wrong");
    a_preset_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        countWrite |=> count_r == $past(countWriteData)) else $error("preset lost");
    // outside two-wire only the external edge option may raise the start flag
    a_start_only_two: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wireModeSelect[1] && !(externalClockSelect && !softwareShiftStrobe) && !start_r
        |=> !start_r) else $error("start outside two-wire");
    a_start_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
        startCond |=> start_r ##1 startDetectFlag) else $error("start flag missing");
    a_toggle_inverts: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clockToggleStrobe && !clockPortWrite |=> clkPort_r != $past(clkPort_r))
        else $error("toggle failed");
    a_hold_keeps_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        startHold_r && clockLineDirectionBit && twoWire |=> !clockLineOe_n)
        else $error("clock not held");
    a_ovf_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wireModeSelect == WM_TWO_HOLD && ovf_r && clockLineDirectionBit |=> !clockLineOe_n)
        else $error("overflow hold missing");
    a_shift_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
        shiftEdge && !shiftWrite |=> shift_r[WIDTH-1:1] == $past(shift_r[WIDTH-2:0]))
        else $error("shift wrong");

    c_overflow: cover property (@(posedge clk_sys) disable iff (sys_rst) overflowEvt);
    c_start: cover property (@(posedge clk_sys) disable iff (sys_rst) startCond);
    c_edge_start: cover property (@(posedge clk_sys) disable iff (sys_rst) edgeStart);
    c_sw_shift: cover property (@(posedge clk_sys) disable iff (sys_rst) swShift ##1 swShift);
endmodule : universal_serial_shift_unit

// [verification/serial_partner_model.sv]
// behavioural three-wire master on the far side of the shift unit
// assumes mode 0 timing and a 320 ns link clock that stands still between frames
`timescale 1ns/1ps
module serial_partner_model (
    input wire logic start,
    input wire logic [7:0] txByte,
    input wire logic misoIn,
    output logic sclk,
    output logic mosi,
    output logic [7:0] rxByte,
    output logic busy
);
    initial
    begin
        sclk = 1'b0;
        mosi = 1'b0;
        rxByte = 8'h00;
        busy = 1'b0;
    end

    // one frame per start rise, most significant bit first
    always @(posedge start)
    begin
        busy = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            mosi = txByte[i];
            #160 sclk = 1'b1;
            #150 rxByte = {rxByte[6:0], misoIn};
            #10 sclk = 1'b0;
        end
        // a released data line no longer shows the last bit
        #160 mosi = ~mosi;
        busy = 1'b0;
    end
endmodule : serial_partner_model

// [verification/test_universal_serial_shift_unit.sv]
// self-checking bench for the universal serial shift unit
// assumes the partner model as master and open-drain clock wire resolution here
`timescale 1ns/1ps
module test_universal_serial_shift_unit;
    import serial_shift_pkg::*;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic [1:0] wm = WM_OFF;
    logic ext = 0, edgeSel = 0, swStrobe = 0, tog = 0, shW = 0, cntW = 0;
    logic ovfClr = 0, stClr = 0, dDir = 0, cpW = 0, cDir = 0, go = 0;
    logic useModel = 0, sclTb = 1, sdaTb = 1, dPort = 1;
    logic [7:0] shD = 8'h00;
    logic [3:0] cntD = 4'h0;
    logic [7:0] shData, rx;
    logic [3:0] cnt;
    logic ovf, st, wake, cPort, dOut, dOe_n, cOut, cOe_n, sclk, mosi, busy;
    int err_count = 0;
    int comparisons = 0;
    // open-drain clock: low when the unit drives it low
    wire sclWire = useModel ? sclk : (sclTb & (cOe_n | cOut));
    wire sdaWire = useModel ? mosi : sdaTb;
    wire [2:0] watch = {busy, st, ovf};

    universal_serial_shift_unit u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .wireModeSelect(wm), .externalClockSelect(ext), .clockEdgeSelect(edgeSel),
        .softwareShiftStrobe(swStrobe), .clockToggleStrobe(tog), .shiftWrite(shW),
        .shiftWriteData(shD), .countWrite(cntW), .countWriteData(cntD),
        .overflowClear(ovfClr), .startClear(stClr), .dataLinePortOutput(dPort),
        .dataLineDirectionBit(dDir), .clockPortWrite(cpW), .clockPortWriteData(1'b1),
        .clockLineDirectionBit(cDir), .dataLineIn(sdaWire), .clockLineIn(sclWire),
        .serialShiftData(shData), .counterValue(cnt), .counterOverflowFlag(ovf),
        .startDetectFlag(st), .wakeRequest(wake), .clockLinePortOutput(cPort),
        .dataLineOut(dOut), .dataLineOe_n(dOe_n), .clockLineOut(cOut),
        .clockLineOe_n(cOe_n));

    serial_partner_model u_partner (.start(go), .txByte(8'hA5), .misoIn(dOut),
        .sclk(sclk), .mosi(mosi), .rxByte(rx), .busy(busy));

    // system clock, 40 ns period
    always #20 clk_sys = ~clk_sys;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cycles

    // bounded wait on one watched bit; running out ends the run
    task automatic waitBit(input int idx, input logic lvl);
        int n;
        n = 0;
        while (watch[idx] !== lvl && n < 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (watch[idx] !== lvl)
        begin
            err_count++;
            conclude();
        end
    endtask : waitBit

    // byte exchange against the partner with external mode 0 clocking
    task automatic spiExchange;
        wm = WM_THREE;
        ext = 1;
        dDir = 1;
        useModel = 1;
        // handing the wire to the idle-low model gives one fall; let it pass first
        cycles(6);
        shW = 1;
        shD = 8'h3C;
        cntW = 1;
        @(negedge clk_sys);
        shW = 0;
        cntW = 0;
        cycles(6);
        go = 1;
        waitBit(2, 1'b1);
        go = 0;
        waitBit(2, 1'b0);
        cycles(8);
        check(shData, 8'hA5);
        check(rx, 8'h3C);
        check({3'h0, ovf, cnt}, 8'h10);
        check({6'h00, wake, st}, 8'h03);
    endtask : spiExchange

    // software strobes alternating with clock toggles at half rate
    task automatic strobeCount;
        useModel = 0;
        ext = 0;
        cycles(6);
        shW = 1;
        shD = 8'h81;
        cntW = 1;
        cntD = 4'hE;
        ovfClr = 1;
        stClr = 1;
        @(negedge clk_sys);
        shW = 0;
        cntW = 0;
        ovfClr = 0;
        stClr = 0;
        cycles(4);
        check({3'h0, ovf, cnt}, 8'h0E);
        repeat (3)
        begin
            tog = 1;
            @(negedge clk_sys);
            tog = 0;
            swStrobe = 1;
            @(negedge clk_sys);
            swStrobe = 0;
        end
        cycles(3);
        check(shData, 8'h0F);
        check({3'h0, ovf, cnt}, 8'h11);
        check({7'h00, cPort}, 8'h00);
        cpW = 1;
        @(negedge clk_sys);
        cpW = 0;
        cycles(3);
        check({7'h00, cPort}, 8'h01);
    endtask : strobeCount

    // start condition: ignored with outputs off, then held clock in two-wire
    task automatic twoWireStart;
        wm = WM_OFF;
        sdaTb = 0;
        cycles(8);
        check({7'h00, st}, 8'h00);
        sdaTb = 1;
        wm = WM_TWO;
        cDir = 1;
        cycles(8);
        sdaTb = 0;
        waitBit(1, 1'b1);
        sclTb = 0;
        cycles(8);
        sclTb = 1;
        cycles(8);
        check({6'h00, cOe_n, sclWire}, 8'h00);
        stClr = 1;
        @(negedge clk_sys);
        stClr = 0;
        cycles(6);
        check({6'h00, cOe_n, sclWire}, 8'h03);
    endtask : twoWireStart

    // master clocking by toggle strobe: pin edges shift, strobes count
    task automatic toggleCount;
        wm = WM_THREE;
        tog = 1;
        sdaTb = 1;
        @(negedge clk_sys);
        tog = 0;
        cycles(6);
        ext = 1;
        swStrobe = 1;
        shW = 1;
        shD = 8'h00;
        cntW = 1;
        cntD = 4'h0;
        ovfClr = 1;
        @(negedge clk_sys);
        shW = 0;
        cntW = 0;
        ovfClr = 0;
        cycles(2);
        repeat (16)
        begin
            tog = 1;
            @(negedge clk_sys);
            tog = 0;
            cycles(5);
        end
        cycles(4);
        check(shData, 8'hFF);
        check({3'h0, ovf, cnt}, 8'h10);
        check({6'h00, cPort, st}, 8'h00);
    endtask : toggleCount

    // overflow hold in two-wire: clock kept low until the flag is cleared
    task automatic overflowHold;
        wm = WM_TWO_HOLD;
        edgeSel = 0;
        swStrobe = 0;
        sclTb = 0;
        sdaTb = 0;
        cpW = 1;
        ovfClr = 1;
        @(negedge clk_sys);
        cpW = 0;
        ovfClr = 0;
        cycles(6);
        check({7'h00, dOe_n}, 8'h01);
        cntW = 1;
        cntD = 4'hE;
        @(negedge clk_sys);
        cntW = 0;
        cycles(2);
        sclTb = 1;
        cycles(6);
        sclTb = 0;
        cycles(6);
        sclTb = 1;
        cycles(6);
        check({6'h00, cOe_n, sclWire}, 8'h00);
        check({3'h0, ovf, cnt}, 8'h10);
        check(shData, 8'hFE);
        dPort = 0;
        cycles(3);
        check({7'h00, dOe_n}, 8'h00);
        dPort = 1;
        ovfClr = 1;
        @(negedge clk_sys);
        ovfClr = 0;
        cycles(8);
        check({6'h00, cOe_n, sclWire}, 8'h03);
        check({3'h0, ovf, cnt}, 8'h01);
    endtask : overflowHold

    // main sequence
    initial
    begin
        cycles(10);
        sys_rst = 0;
        cycles(2);
        check({cnt, ovf, st, cPort, cOe_n}, 8'h03);
        spiExchange();
        strobeCount();
        twoWireStart();
        toggleCount();
        overflowHold();
        conclude();
    end
endmodule : test_universal_serial_shift_unit
